// file: testbench/dstc_cpu_model.sv
// cpu core model: comparator hits, tagged fetches, tag hits and trace stores
`timescale 1ns/1ps
module dstc_cpu_model
	import dstc_pkg::*;
(
	input  wire logic                sys_clk_i,
	input  wire logic [CHANNELS-1:0] fetch_tag_i,
	output logic      [CHANNELS-1:0] comp_hit_o,
	output logic                     fetch_valid_o,
	output logic      [CHANNELS-1:0] tag_hit_o,
	output logic                     trace_valid_o,
	output logic      [19:0]         trace_data_o
);
	initial begin
		comp_hit_o = '0;
		fetch_valid_o = 1'b0;
		tag_hit_o = '0;
		trace_valid_o = 1'b0;
		trace_data_o = 20'h0;
	end
	// one-cycle comparator hit on the masked channels
	task automatic hit(input logic [CHANNELS-1:0] m);
		comp_hit_o <= m;
		@(posedge sys_clk_i);
		comp_hit_o <= '0;
	endtask
	task automatic fetch(input logic [CHANNELS-1:0] m, input int lat);
		logic [CHANNELS-1:0] seen;
		comp_hit_o <= m;
		fetch_valid_o <= 1'b1;
		@(posedge sys_clk_i);
		comp_hit_o <= '0;
		fetch_valid_o <= 1'b0;
		// tags are registered, so look mid-cycle when they have settled
		@(negedge sys_clk_i);
		seen = fetch_tag_i;
		repeat (lat) @(posedge sys_clk_i);
		tag_hit_o <= seen;
		@(posedge sys_clk_i);
		tag_hit_o <= '0;
	endtask
	// line i carries its index in the top nibble and 16'hc000 plus its index in the low word
	task automatic store(input int n);
		for (int i = 0; i < n; i++) begin
			trace_valid_o <= 1'b1;
			trace_data_o <= {4'(i), 16'hc000 + 16'(i)};
			@(posedge sys_clk_i);
		end
		trace_valid_o <= 1'b0;
		// released data must not look like the last line
		trace_data_o <= ~trace_data_o;
	endtask
endmodule

// file: testbench/test_debug_sequencer_trace_control.sv
// testbench: register-level tests of the debug sequencer with a cpu model
`timescale 1ns/1ps
module test_debug_sequencer_trace_control
	import dstc_pkg::*;
;
	localparam logic [31:0] ARM = 32'h1 << CTL_ARM_BIT;
	localparam logic [31:0] TRG = 32'h1 << CTL_IMMEDIATE_TRIGGER_BIT_BIT;
	localparam logic [31:0] SRC = 32'h1 << TCR_SRC_BIT;
	localparam logic [31:0] BEG = 32'h1 << TCR_ALIGN_BIT;
	localparam logic [31:0] TAG = 32'h1 << CMP_TAG_BIT;
	localparam logic [31:0] CHANNEL_BREAK_ENABLE = 32'h1 << CMP_BRK_BIT;
	logic                clk;
	logic                rst;
	logic                rd_en;
	logic                wr_en;
	logic                background_debug_mode;
	logic [5:0]          adr;
	logic [31:0]         wdata;
	logic [31:0]         rdata;
	logic                wait_req, channel_break_enable, trc, fv, tv;
	logic [CHANNELS-1:0] hit, thit, ftag;
	logic [19:0]         td;
	int                  error_cnt = 0;
	int                  cmp_count = 0;
	int                  brk_cnt   = 0;

	always #4 clk = ~clk;
	always @(posedge clk) if (channel_break_enable === 1'b1) brk_cnt <= brk_cnt + 1;

	dstc_core i_dstc_core (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .comp_hit_i(hit),
		.fetch_valid_i(fv), .tag_hit_i(thit), .trace_valid_i(tv), .trace_data_i(td),
		.background_debug_mode_i(background_debug_mode), .fetch_tag_o(ftag), .break_req_o(channel_break_enable),
		.tracing_o(trc));
	dstc_cpu_model i_dstc_cpu_model (.sys_clk_i(clk), .fetch_tag_i(ftag),
		.comp_hit_o(hit), .fetch_valid_o(fv), .tag_hit_o(thit),
		.trace_valid_o(tv), .trace_data_o(td));

	task automatic end_of_test();
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held to the edge where waitrequest is sampled low; data taken there
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic wt;
		int   n;
		adr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= ~w;
		n = 0;
		do begin
			@(posedge clk);
			wt = wait_req;
			n++;
		end while (wt !== 1'b0 && n < 40);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (wt !== 1'b0) begin
			error_cnt++;
			$display("[ERR] bus answer expected 0 seen %b", wt);
			end_of_test();
		end
		@(posedge clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(nm, e, q & m);
	endtask
	task automatic wait_brk(input int e);
		int n;
		n = 0;
		while (brk_cnt < e && n < 200) begin
			@(posedge clk);
			n++;
		end
		cmp("break seen", 32'h1, {31'h0, brk_cnt >= e});
	endtask
	task automatic wait_trc(input logic v, input int b);
		int n;
		n = 0;
		while (trc !== v && n < b) begin
			@(posedge clk);
			n++;
		end
		cmp("tracing", {31'h0, v}, {31'h0, trc});
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("[ERR] run length expected done seen hang");
		end_of_test();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		rd_en = 1'b0;
		wr_en = 1'b0;
		background_debug_mode = 1'b0;
		adr = 6'h00;
		wdata = 32'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk("arm at reset", ADDR_CONTROL_ONE, ARM, 32'h0);
		rchk("status at reset", ADDR_STATUS, 32'h3f, 32'h0);
		cmp("break at reset", 32'h0, 32'(brk_cnt));
		rchk("unmapped", 6'h30, 32'hffffffff, 32'h0);
		// forced matches under end alignment: ch0 to 3, ch1 to final, ch2 to 1
		wr(ADDR_TRACE_CTL, SRC);
		wr(ADDR_STATE_CTL1, 32'h2);
		wr(ADDR_STATE_CTL2, {26'h0, 2'h1, NEXT_FINAL, 2'h3});
		wr(ADDR_CONTROL_ONE, ARM);
		rchk("armed", ADDR_STATUS, 32'h7, 32'h1);
		wait_trc(1'b1, 8);
		i_dstc_cpu_model.store(5);
		rchk("window armed", ADDR_WIN_HIGH, 32'hffffffff, BAD_READ);
		rchk("line count", ADDR_LINE_CNT, 32'hffffffff, 32'h5);
		i_dstc_cpu_model.hit(3'b001);
		repeat (2) @(posedge clk);
		rchk("forced move", ADDR_STATUS, 32'h3f, 32'h0a);
		wr(ADDR_STATUS, 32'h0);
		i_dstc_cpu_model.hit(3'b011);
		wait_brk(1);
		rchk("final wins", ADDR_STATUS, 32'h3f, 32'h10);
		wait_trc(1'b0, 1);
		rchk("disarmed", ADDR_CONTROL_ONE, ARM, 32'h0);
		for (int k = 0; k < 2; k++) begin
			rchk("line high", ADDR_WIN_HIGH, 32'hffffffff, 32'(k));
			rchk("line low", ADDR_WIN_LOW, 32'hffffffff, 32'hc000 + 32'(k));
		end
		// trigger under end alignment while armed
		wr(ADDR_CONTROL_ONE, ARM);
		rchk("rearmed", ADDR_STATUS, 32'h7, 32'h1);
		wr(ADDR_CONTROL_ONE, ARM | TRG);
		wait_brk(2);
		rchk("trigger end", ADDR_STATUS, 32'h7, 32'h0);
		// trigger under begin alignment from disarmed, stores blocked in debug mode
		wr(ADDR_TRACE_CTL, SRC | BEG);
		wr(ADDR_CONTROL_ONE, ARM | TRG);
		rchk("trigger begin", ADDR_STATUS, 32'h7, 32'(DSTC_FINAL));
		wait_trc(1'b1, 4);
		background_debug_mode <= 1'b1;
		i_dstc_cpu_model.store(64);
		background_debug_mode <= 1'b0;
		wait_trc(1'b1, 0);
		i_dstc_cpu_model.store(64);
		wait_brk(3);
		rchk("session done", ADDR_CONTROL_ONE, ARM, 32'h0);
		rchk("idle again", ADDR_STATUS, 32'h7, 32'h0);
		// tagged ch2, break on ch0, no trace source
		wr(ADDR_TRACE_CTL, 32'h0);
		wr(ADDR_COMP_CTL0, CHANNEL_BREAK_ENABLE);
		wr(ADDR_COMP_CTL2, TAG);
		wr(ADDR_STATE_CTL1, 32'h31);
		wr(ADDR_STATE_CTL3, {30'h0, NEXT_FINAL});
		wr(ADDR_STATUS, 32'h0);
		wr(ADDR_CONTROL_ONE, ARM);
		i_dstc_cpu_model.hit(3'b100);
		repeat (4) @(posedge clk);
		rchk("forced ignored", ADDR_STATUS, 32'h3f, 32'h01);
		i_dstc_cpu_model.hit(3'b001);
		wait_brk(4);
		rchk("break only", ADDR_STATUS, 32'h3f, 32'h09);
		wr(ADDR_STATUS, 32'h0);
		i_dstc_cpu_model.fetch(3'b100, 3);
		rchk("tagged move", ADDR_STATUS, 32'h3f, 32'h23);
		i_dstc_cpu_model.hit(3'b001);
		wait_brk(5);
		rchk("ended", ADDR_STATUS, 32'h7, 32'h0);
		rchk("arm cleared", ADDR_CONTROL_ONE, ARM, 32'h0);
		end_of_test();
	end
endmodule

// file: verilog/dstc_core.sv
// debug sequencer with comparator match modes, trigger and circular trace store
// Notes on behaviour
// - per-channel tag bit picks forced or tagged match as the sequencer qualifier.
// - forced match moves to next state from state control, sets channel flags.
// - forced match lands 2-3 cycles after matching cycle, direction independent.
// - device tags fetches; cpu tag hit at execution transitions and sets flags.
// - trigger bit: begin alignment enters final; end alignment disarms and breaks.
// - trigger written with arm together triggers regardless of prior arm.
// - priority: trigger, channel to final, then channels 0, 1, 2.
// - arm moves state0 to state1; then state control and matches steer.
// - final state only goes to state0; states 1 to 3 move freely.
// - every transition updates the three-bit state field in status.
// - break-enabled channels request breakpoint on match, independent of sequencer.
// - session end without begin-aligned tracing passes final for one cycle then state0, disarmed.
// - final entry triggers trace per alignment; without source, only break, disarm.
// - with tracing, disarm and return to state0 when session completes.
// - trace store is 64 lines of 20 bits, written circularly.
// - window read as 4-bit high and 16-bit low parts; pointer advances after full line read.
// - line counter increments after every store.
// - no trace stores while background debug mode is active; tracing_o stays high.
// - window read while armed returns invalid data, pointer unchanged.
// - end alignment traces from arming into state1 until final entry.
// - begin traces at trigger; write-started tracing begins second cycle after.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module dstc_core
	import dstc_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH,
	parameter int WIDTH = TRACE_WIDTH
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [5:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	input  wire logic [CHANNELS-1:0]   comp_hit_i,
	input  wire logic                  fetch_valid_i,
	input  wire logic [CHANNELS-1:0]   tag_hit_i,
	input  wire logic                  trace_valid_i,
	input  wire logic [WIDTH-1:0]      trace_data_i,
	input  wire logic                  background_debug_mode_i,
	output logic      [CHANNELS-1:0]   fetch_tag_o,
	output logic                       break_req_o,
	output logic                       tracing_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int MATCH_DELAY = 2;

	dstc_state_t state;
	logic [7:0]          debug_control_one;
	logic [1:0]          trace_control_reg;
	logic [1:0]          comparator_control_reg [CHANNELS];
	logic [5:0]          state_ctl [3];
	logic [CHANNELS-1:0] chan_flags;
	logic [WIDTH-1:0]    trace_mem [DEPTH];
	logic [PW-1:0]       wr_ptr;
	logic [PW-1:0]       rd_ptr;
	logic [15:0]         trace_line_counter;
	logic [CHANNELS-1:0] hit_d1;
	logic [CHANNELS-1:0] hit_d2;
	logic [1:0]          start_dly;
	logic                trace_on;
	logic                begin_run;
	logic                rd_done;
	logic                high_read;
	logic [WIDTH-1:0]    line_latch;

	// next state chosen by a state's control for a given channel
	function automatic dstc_state_t chan_next(input logic [5:0] ctl, input int ch);
		logic [1:0] code;
		code = ctl[ch*2 +: 2];
		if (code == NEXT_FINAL)
			return DSTC_FINAL;
		return dstc_state_t'({1'b0, code});
	endfunction

	wire logic armed = debug_control_one[CTL_ARM_BIT];
	wire logic align_begin = trace_control_reg[TCR_ALIGN_BIT];
	wire logic src_en = trace_control_reg[TCR_SRC_BIT];
	wire logic wr_acc = avs_write_i & ~avs_waitrequest_o;
	wire logic wr_ctl = wr_acc & (avs_address_i == ADDR_CONTROL_ONE);
	wire logic wr_immediate_trigger_bit = wr_ctl & avs_writedata_i[CTL_IMMEDIATE_TRIGGER_BIT_BIT];
	wire logic wr_arm = wr_ctl & avs_writedata_i[CTL_ARM_BIT];
	wire logic [5:0] cur_ctl = (state inside {DSTC_ST1, DSTC_ST2, DSTC_ST3}) ?
		state_ctl[state[1:0] - 2'h1] : 6'h00;

	// per-channel qualified match, forced or tagged
	logic [CHANNELS-1:0] chan_match;
	logic [CHANNELS-1:0] chan_brk;
	logic [CHANNELS-1:0] to_final;
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			// forced hit delayed two cycles, direction ignored
			chan_match[c] = comparator_control_reg[c][CMP_TAG_BIT] ? tag_hit_i[c] : hit_d2[c];
			chan_brk[c] = chan_match[c] & comparator_control_reg[c][CMP_BRK_BIT];
			to_final[c] = chan_match[c] & (chan_next(cur_ctl, c) == DSTC_FINAL);
		end
	end

	logic        seq_go;
	int          win_ch;
	always_comb begin
		seq_go = 1'b0;
		win_ch = 0;
		if (state inside {DSTC_ST1, DSTC_ST2, DSTC_ST3}) begin
			if (|to_final) begin
				seq_go = 1'b1;
				win_ch = to_final[0] ? 0 : (to_final[1] ? 1 : 2);
			end else if (|chan_match) begin
				seq_go = 1'b1;
				win_ch = chan_match[0] ? 0 : (chan_match[1] ? 1 : 2);
			end
		end
	end

	wire logic trace_full = (trace_line_counter >= 16'(DEPTH));
	wire logic begin_done = begin_run & trace_full;

	// tag fetched instructions for tagged channels
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fetch_tag_o <= '0;
			hit_d1 <= '0;
			hit_d2 <= '0;
		end else begin
			for (int c = 0; c < CHANNELS; c++)
				fetch_tag_o[c] <= fetch_valid_i & comparator_control_reg[c][CMP_TAG_BIT];
			hit_d1 <= comp_hit_i;
			hit_d2 <= hit_d1;
		end
	end

	// sequencer and control registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= DSTC_ST0;
			debug_control_one <= 8'h00;
			trace_control_reg <= 2'h0;
			chan_flags <= '0;
			break_req_o <= 1'b0;
			begin_run <= 1'b0;
			start_dly <= 2'h0;
			for (int i = 0; i < CHANNELS; i++)
				comparator_control_reg[i] <= 2'h0;
			for (int i = 0; i < 3; i++)
				state_ctl[i] <= 6'h00;
		end else begin
			break_req_o <= 1'b0;
			start_dly <= {start_dly[0], 1'b0};
			if (|chan_brk)
				break_req_o <= 1'b1;
			if (wr_acc && avs_address_i == ADDR_TRACE_CTL)
				trace_control_reg <= avs_writedata_i[1:0];
			if (wr_acc && avs_address_i == ADDR_COMP_CTL0)
				comparator_control_reg[0] <= avs_writedata_i[1:0];
			if (wr_acc && avs_address_i == ADDR_COMP_CTL1)
				comparator_control_reg[1] <= avs_writedata_i[1:0];
			if (wr_acc && avs_address_i == ADDR_COMP_CTL2)
				comparator_control_reg[2] <= avs_writedata_i[1:0];
			if (wr_acc && avs_address_i == ADDR_STATE_CTL1)
				state_ctl[0] <= avs_writedata_i[5:0];
			if (wr_acc && avs_address_i == ADDR_STATE_CTL2)
				state_ctl[1] <= avs_writedata_i[5:0];
			if (wr_acc && avs_address_i == ADDR_STATE_CTL3)
				state_ctl[2] <= avs_writedata_i[5:0];
			if (wr_ctl)
				debug_control_one <= {avs_writedata_i[7], 1'b0, avs_writedata_i[5:0]};
			if (wr_acc && avs_address_i == ADDR_STATUS)
				chan_flags <= '0;
			// trigger with arm triggers whatever arm was
			if (wr_immediate_trigger_bit && (armed || wr_arm)) begin
				if (align_begin) begin
					// write-started trace begins second cycle later
					state <= DSTC_FINAL;
					start_dly <= 2'h1;
				end else begin
					state <= DSTC_ST0;
					debug_control_one[CTL_ARM_BIT] <= 1'b0;
					break_req_o <= 1'b1;
				end
			end else if (wr_arm && state == DSTC_ST0) begin
				state <= DSTC_ST1;
				// one stage shorter than the trigger path, so tracing opens in the second cycle after the write
				if (!align_begin)
					start_dly <= 2'h2;
			end else if (wr_ctl && !avs_writedata_i[CTL_ARM_BIT]) begin
				state <= DSTC_ST0;
				begin_run <= 1'b0;
			end else if (seq_go) begin
				// forced or tagged transition, set flags
				state <= chan_next(cur_ctl, win_ch);
				chan_flags[win_ch] <= 1'b1;
			end else if (state == DSTC_FINAL) begin
				// trigger trace by alignment, else break and disarm
				if (align_begin && src_en && !begin_run && !begin_done) begin
					begin_run <= 1'b1;
				end else if (!(align_begin && src_en) || begin_done) begin
					// one cycle in final then state0
					state <= DSTC_ST0;
					debug_control_one[CTL_ARM_BIT] <= 1'b0;
					begin_run <= 1'b0;
					break_req_o <= 1'b1;
				end
			end
		end
	end

	// tracing gate
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			trace_on <= 1'b0;
		else if (start_dly[1] || (state == DSTC_FINAL && align_begin && src_en && !begin_run))
			trace_on <= src_en;
		else if (!armed || state == DSTC_FINAL && !begin_run || begin_done)
			trace_on <= 1'b0;
	end
	wire logic store = trace_on & trace_valid_i & ~background_debug_mode_i & ~begin_done;
	assign tracing_o = trace_on;

	always_ff @(posedge sys_clk_i) begin
		if (store)
			trace_mem[wr_ptr] <= trace_data_i;
	end

	wire logic rd_acc = avs_read_i & ~avs_waitrequest_o;
	wire logic rd_high = rd_acc & (avs_address_i == ADDR_WIN_HIGH);
	wire logic rd_low = rd_acc & (avs_address_i == ADDR_WIN_LOW);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			trace_line_counter <= 16'h0000;
			high_read <= 1'b0;
		end else begin
			if (store) begin
				wr_ptr <= wr_ptr + PW'(1);
				trace_line_counter <= trace_line_counter + 16'h0001;
			end
			if (wr_arm && state == DSTC_ST0) begin
				trace_line_counter <= 16'h0000;
				wr_ptr <= '0;
				rd_ptr <= '0;
			end
			// pointer advances after both halves read
			if (!armed && rd_high)
				high_read <= 1'b1;
			if (!armed && rd_low && high_read) begin
				rd_ptr <= rd_ptr + PW'(1);
				high_read <= 1'b0;
			end
		end
	end

	// Avalon slave: one wait cycle on every access, so the pipeline reads stable data
	logic wait_done;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			wait_done <= 1'b0;
		else
			wait_done <= (avs_read_i | avs_write_i) & ~wait_done;
	end
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~wait_done;

	wire logic [WIDTH-1:0] rd_line = trace_mem[rd_ptr];
	logic [31:0] next_rdata;
	always_comb begin
		unique case (avs_address_i)
			ADDR_CONTROL_ONE: next_rdata = {24'h0, debug_control_one};
			ADDR_STATUS:      next_rdata = {24'h0, 2'h0, chan_flags, state};
			ADDR_TRACE_CTL:   next_rdata = {30'h0, trace_control_reg};
			ADDR_COMP_CTL0:   next_rdata = {30'h0, comparator_control_reg[0]};
			ADDR_COMP_CTL1:   next_rdata = {30'h0, comparator_control_reg[1]};
			ADDR_COMP_CTL2:   next_rdata = {30'h0, comparator_control_reg[2]};
			ADDR_STATE_CTL1:  next_rdata = {26'h0, state_ctl[0]};
			ADDR_STATE_CTL2:  next_rdata = {26'h0, state_ctl[1]};
			ADDR_STATE_CTL3:  next_rdata = {26'h0, state_ctl[2]};
			ADDR_WIN_HIGH:    next_rdata = armed ? BAD_READ : {28'h0, rd_line[19:16]};
			ADDR_WIN_LOW:     next_rdata = armed ? BAD_READ : {16'h0, rd_line[15:0]};
			ADDR_LINE_CNT:    next_rdata = {16'h0, trace_line_counter};
			default:          next_rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i)
			avs_readdata_o <= next_rdata;
	end

	// a_reset_disarmed guards reset state
	a_reset_disarmed: assert property (@(posedge sys_clk_i) $fell(rst_i) |-> state == DSTC_ST0 && !armed)
		else $error("not disarmed after reset");
	// a_final_exit_only guards final exits
	a_final_exit_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$past(state) == DSTC_FINAL && state != DSTC_FINAL |-> state == DSTC_ST0)
		else $error("final left to non-zero state");
	// a_arm_enters_one guards arming
	a_arm_enters_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_arm && !wr_immediate_trigger_bit && state == DSTC_ST0 |=> state == DSTC_ST1)
		else $error("arm did not enter state1");
	// a_forced_delay guards match timing
	a_forced_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		comp_hit_i[0] |-> ##2 (chan_match[0] || comparator_control_reg[0][CMP_TAG_BIT]))
		else $error("forced match delay wrong");
	// a_brk_request guards breakpoints
	a_brk_request: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		|chan_brk |=> break_req_o)
		else $error("breakpoint not requested");
	// a_immediate_trigger_bit_end_align guards end trigger
	a_immediate_trigger_bit_end_align: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_immediate_trigger_bit && wr_arm && !align_begin |=> state == DSTC_ST0 && !armed && break_req_o)
		else $error("end-aligned trigger wrong");
	// a_count_store guards counter
	a_count_store: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		store && !(wr_arm && state == DSTC_ST0) |=>
		trace_line_counter == $past(trace_line_counter) + 16'h0001)
		else $error("line counter missed store");
	// a_armed_no_adv guards read pointer
	a_armed_no_adv: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		armed && !(wr_arm && state == DSTC_ST0) |=> rd_ptr == $past(rd_ptr))
		else $error("pointer moved while armed");
	// a_no_bdm_trace guards debug mode
	a_no_bdm_trace: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		background_debug_mode_i |=> wr_ptr == $past(wr_ptr) || $past(wr_arm))
		else $error("stored during background debug");
endmodule

// file: verilog/dstc_pkg.sv
// package: register map, field positions and constants of the debug sequencer
package dstc_pkg;
	// register word byte addresses
	localparam logic [5:0] ADDR_CONTROL_ONE = 6'h00;
	localparam logic [5:0] ADDR_STATUS      = 6'h04;
	localparam logic [5:0] ADDR_TRACE_CTL   = 6'h08;
	localparam logic [5:0] ADDR_COMP_CTL0   = 6'h0c;
	localparam logic [5:0] ADDR_COMP_CTL1   = 6'h10;
	localparam logic [5:0] ADDR_COMP_CTL2   = 6'h14;
	localparam logic [5:0] ADDR_STATE_CTL1  = 6'h18;
	localparam logic [5:0] ADDR_STATE_CTL2  = 6'h1c;
	localparam logic [5:0] ADDR_STATE_CTL3  = 6'h20;
	localparam logic [5:0] ADDR_WIN_HIGH    = 6'h24;
	localparam logic [5:0] ADDR_WIN_LOW     = 6'h28;
	localparam logic [5:0] ADDR_LINE_CNT    = 6'h2c;
	// control one fields
	localparam int CTL_ARM_BIT  = 7;
	localparam int CTL_IMMEDIATE_TRIGGER_BIT_BIT = 6;
	// trace control fields
	localparam int TCR_SRC_BIT   = 1;
	localparam int TCR_ALIGN_BIT = 0;
	// comparator control fields
	localparam int CMP_TAG_BIT = 1;
	localparam int CMP_BRK_BIT = 0;
	// trace store geometry
	localparam int TRACE_DEPTH = 64;
	localparam int TRACE_WIDTH = 20;
	localparam int CHANNELS    = 3;
	// sequencer states, encoded as in the state field
	typedef enum logic [2:0] {
		DSTC_ST0   = 3'h0,
		DSTC_ST1   = 3'h1,
		DSTC_ST2   = 3'h2,
		DSTC_ST3   = 3'h3,
		DSTC_FINAL = 3'h4
	} dstc_state_t;
	localparam logic [1:0] NEXT_FINAL = 2'h0;
	localparam logic [31:0] BAD_READ  = 32'hdeadbeef;
endpackage
